// *** hdl/tscb_device.sv ***
// device end: serial shift register, latches and mode banks
`timescale 1ns/10ps
`default_nettype none
`include "tscb_params.svh"

// How it works
// - shift data in on each serial clock rise
// - strobe rise copies word into addressed latch
// - host keeps clock, data low during strobe
// - extra leading bits fall off the top
// - first bit shifted lands at bit 23
// - host sends four words, or one to change
// - host never sends the reserved test address
// - words accepted in standby and operation
// - bits 1:0 set amplifier mode, reset 00
// - bits 2..5 enable mixer, if, limiter, rssi
// - bit 6 routes lowpass input to rssi
// - bit 7 lowpass amp, bit 8 slicer
// - bits 10:9 power amp, nonzero enables modulation
// - host sets oscillator bit while operating
// - bit 12 enables whole synthesizer loop
// - demodulator auto on: limiter, lowpass, demod route
// - all bank fields reset to zero
// - two banks, identical layout, separate words
// - mode pin picks active bank anytime
// - standby low powers down, programming continues
// - second word holds pump, divider, modulation, slicer

module tscb_device import tscb_pkg::*; (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   tscb_if.device link, // pins from the host
   output logic [1:0] o_lna_mode, // amplifier mode
   output logic o_mixer_en, // mixer on
   output logic o_if_amp_en, // first if amp on
   output logic o_limiter_en, // limiter on
   output logic o_rssi_en, // strength indicator on
   output logic o_data_route, // 1 routes to rssi
   output logic o_lowpass_amp_en, // lowpass amp on
   output logic o_slicer_en, // data slicer on
   output logic [1:0] o_pa_mode, // power amp code
   output logic o_tx_mod_en, // modulation from tx pin
   output logic o_osc_en, // internal oscillator on
   output logic o_synth_en, // synthesizer loop on
   output logic o_demod_en, // fm demodulator on
   output logic [21:0] o_freq_word, // active frequency word
   output logic [7:0] o_fsk_dev, // fsk deviation
   output logic [2:0] o_pump_factor, // acquisition pump factor
   output logic o_loop_div_sel, // 0 gives 256, 1 gives 512
   output logic o_mod_kind, // modulation kind
   output logic o_slicer_learn // 1 learning, 0 hold
);

   // address decode, used by the load logic
   function automatic tscb_latch_sel_t addr_to_sel(
      input logic [`TSCB_ADDR_W-1:0] addr
   );
      tscb_latch_sel_t sel;
      sel = TSCB_SEL_NONE;
      unique case (addr)
         `TSCB_ADDR_FREQ0: sel = TSCB_SEL_FREQ0;
         `TSCB_ADDR_FREQ1: sel = TSCB_SEL_FREQ1;
         `TSCB_ADDR_MODE1: sel = TSCB_SEL_MODE1;
         `TSCB_ADDR_MODE0: sel = TSCB_SEL_MODE0;
         // test code and spares load nothing
         default: sel = TSCB_SEL_NONE;
      endcase
      return sel;
   endfunction

   logic [4:0] pins_sync; // synchronised pin levels
   logic sclk_s; // settled serial clock
   logic sdata_s; // settled serial data
   logic stb_s; // settled strobe
   logic mode_s; // settled mode select
   logic run_s; // settled standby pin, 1 = operate
   logic sclk_d; // serial clock one cycle back
   logic stb_d; // strobe one cycle back
   logic sclk_rise; // serial clock edge seen
   logic stb_rise; // strobe edge seen
   logic [23:0] shreg; // incoming word
   logic [23:0] freq0; // mode 0 frequency latch
   logic [23:0] freq1; // mode 1 frequency latch
   logic [23:0] mode1; // mode 1 enables and extras
   logic [23:0] mode0; // mode 0 enables and deviation
   tscb_latch_sel_t sel; // latch picked by the word
   logic [12:0] bank; // bank in force
   logic [12:0] live; // bank gated by standby
   logic [23:0] act_freq; // frequency word in force
   logic next_demod; // derived demodulator enable

   // pins come from another domain: two flops first
   tscb_sync #(
      .W(5)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({link.serial_clk, link.serial_data, link.strobe,
                link.mode_select, link.standby_pin}),
      .o_sync(pins_sync)
   );

   assign sclk_s = pins_sync[4];
   assign sdata_s = pins_sync[3];
   assign stb_s = pins_sync[2];
   assign mode_s = pins_sync[1];
   assign run_s = pins_sync[0];

   // edge history, taken from the settled stage only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_d <= 1'b0;
         stb_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         stb_d <= stb_s;
      end
   end

   // data and clock share one sync delay, so the bit
   // seen at the clock edge is the one the host set up
   assign sclk_rise = sclk_s & ~sclk_d;
   // host keeps clock low while strobe is high, so a
   // shift and a load never meet in one cycle
   assign stb_rise = stb_s & ~stb_d;
   assign sel = addr_to_sel(shreg[`TSCB_ADDR_MSB:`TSCB_ADDR_LSB]);

   // shift in at the bottom; the oldest bits drop off the top
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shreg <= `TSCB_LATCH_RST;
      end else if (sclk_rise) begin
         shreg <= {shreg[22:0], sdata_s};
      end
   end

   // load the addressed latch; standby does not block it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freq0 <= `TSCB_LATCH_RST;
         freq1 <= `TSCB_LATCH_RST;
         mode1 <= `TSCB_LATCH_RST;
         mode0 <= `TSCB_LATCH_RST;
      end else if (stb_rise) begin
         // unselected latches keep their value
         unique case (sel)
            TSCB_SEL_FREQ0: freq0 <= shreg;
            TSCB_SEL_FREQ1: freq1 <= shreg;
            TSCB_SEL_MODE1: mode1 <= shreg;
            TSCB_SEL_MODE0: mode0 <= shreg;
            TSCB_SEL_NONE: ; // reserved test code ignored
         endcase
      end
   end

   // mode pin picks a bank with no reprogramming
   assign bank = mode_s ? mode1[12:0] : mode0[12:0];
   assign act_freq = mode_s ? freq1 : freq0;
   // standby forces every block off, route back to demod
   assign live = run_s ? bank : 13'h0000;
   assign next_demod = live[`TSCB_LIM_BIT] & live[`TSCB_LPF_BIT]
                       & ~live[`TSCB_ROUTE_BIT];

   // outputs registered; one cycle behind the latches,
   // which matters little beside the sync delay
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_lna_mode <= 2'h0;
         o_mixer_en <= 1'b0;
         o_if_amp_en <= 1'b0;
         o_limiter_en <= 1'b0;
         o_rssi_en <= 1'b0;
         o_data_route <= 1'b0;
         o_lowpass_amp_en <= 1'b0;
         o_slicer_en <= 1'b0;
         o_pa_mode <= 2'h0;
         o_tx_mod_en <= 1'b0;
         o_osc_en <= 1'b0;
         o_synth_en <= 1'b0;
         o_demod_en <= 1'b0;
      end else begin
         o_lna_mode <= live[`TSCB_LNA_MSB:`TSCB_LNA_LSB];
         o_mixer_en <= live[`TSCB_MIX_BIT];
         o_if_amp_en <= live[`TSCB_IF_BIT];
         o_limiter_en <= live[`TSCB_LIM_BIT];
         o_rssi_en <= live[`TSCB_RSSI_BIT];
         o_data_route <= live[`TSCB_ROUTE_BIT];
         o_lowpass_amp_en <= live[`TSCB_LPF_BIT];
         o_slicer_en <= live[`TSCB_SLC_BIT];
         o_pa_mode <= live[`TSCB_PA_MSB:`TSCB_PA_LSB];
         o_tx_mod_en <= |live[`TSCB_PA_MSB:`TSCB_PA_LSB];
         o_osc_en <= live[`TSCB_OSC_BIT];
         o_synth_en <= live[`TSCB_SYN_BIT];
         o_demod_en <= next_demod;
      end
   end

   // static settings pass through standby unchanged,
   // so they are ready the moment the part wakes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_freq_word <= 22'h000000;
         o_fsk_dev <= 8'h00;
         o_pump_factor <= 3'h0;
         o_loop_div_sel <= 1'b0;
         o_mod_kind <= 1'b0;
         o_slicer_learn <= 1'b0;
      end else begin
         o_freq_word <= act_freq[`TSCB_FREQ_W-1:0];
         o_fsk_dev <= mode0[`TSCB_DEV_MSB:`TSCB_DEV_LSB];
         o_pump_factor <= mode1[`TSCB_PUMP_MSB:`TSCB_PUMP_LSB];
         o_loop_div_sel <= mode1[`TSCB_DIV_BIT];
         o_mod_kind <= mode1[`TSCB_MODK_BIT];
         o_slicer_learn <= mode1[`TSCB_SLCM_BIT];
      end
   end

endmodule

`default_nettype wire

// *** hdl/tscb_params.svh ***
// constants of the transceiver serial configuration bank
`ifndef TSCB_PARAMS_SVH
`define TSCB_PARAMS_SVH

// serial word layout
`define TSCB_WORD_W 24
`define TSCB_ADDR_MSB 23
`define TSCB_ADDR_LSB 21
`define TSCB_ADDR_W 3

// latch address codes carried in the word's top bits
`define TSCB_ADDR_FREQ0 3'h0
`define TSCB_ADDR_FREQ1 3'h1
`define TSCB_ADDR_MODE1 3'h2
`define TSCB_ADDR_MODE0 3'h3
`define TSCB_ADDR_TEST 3'h7

// frequency words and deviation
`define TSCB_FREQ_W 22
`define TSCB_DEV_MSB 20
`define TSCB_DEV_LSB 13

// mode bank field positions, same in both banks
`define TSCB_BANK_W 13
`define TSCB_LNA_MSB 1
`define TSCB_LNA_LSB 0
`define TSCB_MIX_BIT 2
`define TSCB_IF_BIT 3
`define TSCB_LIM_BIT 4
`define TSCB_RSSI_BIT 5
`define TSCB_ROUTE_BIT 6
`define TSCB_LPF_BIT 7
`define TSCB_SLC_BIT 8
`define TSCB_PA_MSB 10
`define TSCB_PA_LSB 9
`define TSCB_OSC_BIT 11
`define TSCB_SYN_BIT 12

// second-mode word extras
`define TSCB_PUMP_MSB 20
`define TSCB_PUMP_LSB 18
`define TSCB_DIV_BIT 17
`define TSCB_MODK_BIT 16
`define TSCB_SLCM_BIT 15

// reset value of every latch
`define TSCB_LATCH_RST 24'h000000

// host register map
`define TSCB_REG_WORD 4'h0
`define TSCB_REG_CTRL 4'h4
`define TSCB_REG_STATUS 4'h8
`define TSCB_CTRL_MODE_BIT 0
`define TSCB_CTRL_STBY_BIT 1

// timing
`define TSCB_CLK_PERIOD_NS 5
`define TSCB_SCLK_PERIOD_NS 160
`define TSCB_SCLK_HALF_CYC (((`TSCB_SCLK_PERIOD_NS / 2) + `TSCB_CLK_PERIOD_NS - 1) / `TSCB_CLK_PERIOD_NS)

`endif

// *** hdl/tscb_pkg.sv ***
// types shared by both ends of the serial configuration link
package tscb_pkg;

   // host sequencer states
   typedef enum logic [2:0] {
      TSCB_IDLE = 3'b000,
      TSCB_LOW = 3'b001,
      TSCB_HIGH = 3'b010,
      TSCB_SETTLE = 3'b011,
      TSCB_STROBE = 3'b100
   } tscb_host_state_t;

   // latch chosen by a word's address field
   typedef enum logic [2:0] {
      TSCB_SEL_NONE = 3'b000,
      TSCB_SEL_FREQ0 = 3'b001,
      TSCB_SEL_FREQ1 = 3'b010,
      TSCB_SEL_MODE1 = 3'b011,
      TSCB_SEL_MODE0 = 3'b100
   } tscb_latch_sel_t;

endpackage

// *** hdl/tscb_if.sv ***
// three-wire serial link plus mode and standby pins
`timescale 1ns/10ps
`default_nettype none

interface tscb_if;
   logic serial_clk; // shift clock, made by the host
   logic serial_data; // word bit, msb first
   logic strobe; // load pulse
   logic mode_select; // picks bank 0 or 1
   logic standby_pin; // low powers blocks down

   modport host (
      output serial_clk,
      output serial_data,
      output strobe,
      output mode_select,
      output standby_pin
   );

   modport device (
      input serial_clk,
      input serial_data,
      input strobe,
      input mode_select,
      input standby_pin
   );
endinterface

`default_nettype wire

// *** hdl/tscb_sync.sv ***
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none

module tscb_sync #(
   parameter int W = 1
) (
   input wire logic i_clk, // sampling clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic [W-1:0] i_async, // pin levels
   output logic [W-1:0] o_sync // settled levels
);
   logic [W-1:0] meta; // first stage, read only by second

   // two flops; only the second is visible
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

`default_nettype wire

// *** hdl/tscb_host.sv ***
// host end: register port driving the three-wire link
`timescale 1ns/10ps
`default_nettype none
`include "tscb_params.svh"

module tscb_host import tscb_pkg::*; #(
   parameter int HALF_CYC = `TSCB_SCLK_HALF_CYC
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   tscb_if.host link, // pins to the device
   input wire logic [3:0] i_addr, // register byte address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data, cycle after
   output logic o_busy // word in flight
);
   tscb_host_state_t state; // sequencer state
   logic [7:0] cnt; // half-period counter
   logic [4:0] bits_left; // bits still to send after the current one
   logic [23:0] word; // last word accepted
   logic [23:0] shreg; // word being sent
   logic [1:0] ctrl; // mode select, standby pin
   logic half_done; // half period elapsed
   logic start; // accepted word write
   logic [31:0] next_rdata; // read mux

   assign half_done = (cnt == 8'(HALF_CYC - 1));
   // a write while busy is dropped; software polls status
   assign start = i_wr & (i_addr == `TSCB_REG_WORD) & (state == TSCB_IDLE);
   assign o_busy = (state != TSCB_IDLE);
   assign link.mode_select = ctrl[`TSCB_CTRL_MODE_BIT];
   assign link.standby_pin = ctrl[`TSCB_CTRL_STBY_BIT];
   assign next_rdata = (i_addr == `TSCB_REG_WORD) ? {8'h00, word} :
                       (i_addr == `TSCB_REG_CTRL) ? {30'h0, ctrl} :
                       (i_addr == `TSCB_REG_STATUS) ? {31'h0, o_busy} :
                       32'h00000000;

   // register writes and one-cycle read data
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         word <= 24'h000000;
         ctrl <= 2'h0;
         o_rdata <= 32'h00000000;
      end else begin
         o_rdata <= i_rd ? next_rdata : 32'h00000000;
         if (start) begin
            word <= i_wdata[23:0]; // one word per latch
         end
         if (i_wr && i_addr == `TSCB_REG_CTRL) begin
            ctrl <= i_wdata[1:0];
         end
      end
   end

   // bit sequencer: data set while clock low, sampled on rise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= TSCB_IDLE;
         cnt <= 8'h00;
         bits_left <= 5'h00;
         shreg <= 24'h000000;
         link.serial_clk <= 1'b0;
         link.serial_data <= 1'b0;
         link.strobe <= 1'b0;
      end else begin
         cnt <= half_done ? 8'h00 : cnt + 8'h01;
         unique case (state)
            TSCB_IDLE: begin
               cnt <= 8'h00;
               if (start) begin
                  // msb goes out first
                  shreg <= i_wdata[23:0];
                  link.serial_data <= i_wdata[23];
                  bits_left <= 5'h17;
                  state <= TSCB_LOW;
               end
            end
            TSCB_LOW: begin
               if (half_done) begin
                  link.serial_clk <= 1'b1;
                  state <= TSCB_HIGH;
               end
            end
            TSCB_HIGH: begin
               if (half_done) begin
                  link.serial_clk <= 1'b0;
                  if (bits_left == 5'h00) begin
                     // quiet lines before the strobe
                     link.serial_data <= 1'b0;
                     state <= TSCB_SETTLE;
                  end else begin
                     shreg <= {shreg[22:0], 1'b0};
                     link.serial_data <= shreg[22];
                     bits_left <= bits_left - 5'h01;
                     state <= TSCB_LOW;
                  end
               end
            end
            TSCB_SETTLE: begin
               if (half_done) begin
                  link.strobe <= 1'b1;
                  state <= TSCB_STROBE;
               end
            end
            TSCB_STROBE: begin
               if (half_done) begin
                  link.strobe <= 1'b0;
                  state <= TSCB_IDLE;
               end
            end
            default: state <= TSCB_IDLE;
         endcase
      end
   end

   // software's job; the host sends words verbatim
endmodule

`default_nettype wire

// *** bench/tscb_link_properties.sv ***
// link checker: framing and timing of the three-wire configuration link
`timescale 1ns/10ps
`default_nettype none

module tscb_link_properties #(
   parameter int HALF_CYC = 4 // host half period in clocks
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic serial_clk, // shift clock from host
   input wire logic serial_data, // word bit from host
   input wire logic strobe // load pulse from host
);
   logic prev_sclk; // shift clock one cycle ago
   logic [5:0] rise_cnt; // rises since the last strobe
   logic [23:0] shadow; // bits as the device should see them
   logic [7:0] high_cnt; // cycles the shift clock has stood high
   wire sclk_rise = serial_clk & ~prev_sclk; // edge the device shifts on

   // mirror of the shift register; strobe clears only the rise count, so each frame counts alone
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_sclk <= 1'b0;
         rise_cnt <= 6'h00;
         shadow <= 24'h000000;
      end else begin
         prev_sclk <= serial_clk;
         if (strobe) begin
            rise_cnt <= 6'h00;
         end else if (sclk_rise) begin
            rise_cnt <= rise_cnt + 6'h01;
            shadow <= {shadow[22:0], serial_data};
         end
      end
   end

   // width of the high phase, read at the falling edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         high_cnt <= 8'h00;
      end else begin
         high_cnt <= serial_clk ? high_cnt + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_strobe_pulse;
      strobe[*4] ##1 !strobe;
   endsequence
   sequence s_strobe_wait;
      (!strobe)[*4] ##1 strobe;
   endsequence

   property p_quiet_under_strobe;
      strobe |-> !serial_clk && !serial_data;
   endproperty
   a_quiet_under_strobe: assert property (p_quiet_under_strobe)
      else $error("clock or data high while strobe is high");
   property p_data_steady;
      serial_clk |-> $stable(serial_data);
   endproperty
   a_data_steady: assert property (p_data_steady)
      else $error("data moved while shift clock high");
   property p_clk_width;
      $fell(serial_clk) |-> high_cnt == HALF_CYC;
   endproperty
   a_clk_width: assert property (p_clk_width)
      else $error("shift clock high phase has wrong width");
   property p_word_bits;
      $rose(strobe) |-> rise_cnt == 6'h18;
   endproperty
   a_word_bits: assert property (p_word_bits)
      else $error("strobe not preceded by exactly 24 bits");
   property p_no_test_addr;
      $rose(strobe) |-> shadow[23:21] != 3'h7;
   endproperty
   a_no_test_addr: assert property (p_no_test_addr)
      else $error("host loaded the reserved address");
   property p_strobe_len;
      $rose(strobe) |-> s_strobe_pulse;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe pulse has wrong length");
   property p_strobe_follows;
      $fell(serial_clk) && rise_cnt == 6'h18 |-> s_strobe_wait;
   endproperty
   a_strobe_follows: assert property (p_strobe_follows)
      else $error("strobe not issued one half period after last bit");
   property p_frame_gap;
      $fell(strobe) |-> (!serial_clk)[*4];
   endproperty
   a_frame_gap: assert property (p_frame_gap)
      else $error("next frame began too soon after strobe");
endmodule

`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench: host and device joined over the serial link
`timescale 1ns/10ps
`default_nettype none
`include "tscb_params.svh"

module tb;
   logic i_clk, i_rst_n, i_wr, i_rd, o_busy; // bus strobes and status
   logic [3:0] i_addr; // register address
   logic [31:0] i_wdata, o_rdata; // register data
   logic [1:0] o_lna_mode, o_pa_mode, far_lna, far_pa; // coded modes
   logic o_mixer_en, o_if_amp_en, o_limiter_en, o_rssi_en, o_data_route; // bank bits
   logic o_lowpass_amp_en, o_slicer_en, o_tx_mod_en, o_osc_en, o_synth_en, o_demod_en;
   logic [21:0] o_freq_word; // active frequency
   logic [7:0] o_fsk_dev, far_dev; // deviation fields
   logic [2:0] o_pump_factor; // pump factor
   logic o_loop_div_sel, o_mod_kind, o_slicer_learn; // second-mode extras
   int mismatches = 0, checked = 0, cycles = 0; // score and watchdog
   logic [12:0] bank [2]; // expected mode banks
   logic [21:0] freq [2]; // expected frequency words
   logic [7:0] dev; // expected deviation
   logic [5:0] ext; // expected extras
   logic mode, stby; // expected pin levels
   wire [14:0] obs = {o_lna_mode, o_mixer_en, o_if_amp_en, o_limiter_en, o_rssi_en,
      o_data_route, o_lowpass_amp_en, o_slicer_en, o_pa_mode, o_tx_mod_en, o_osc_en,
      o_synth_en, o_demod_en}; // bank outputs in bit order

   tscb_if lk(); // link between the design ends
   tscb_if lk2(); // link the bench drives by hand
   tscb_host #(.HALF_CYC(4)) i_tscb_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_busy(o_busy));
   tscb_device i_tscb_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk),
      .o_lna_mode(o_lna_mode), .o_mixer_en(o_mixer_en), .o_if_amp_en(o_if_amp_en),
      .o_limiter_en(o_limiter_en), .o_rssi_en(o_rssi_en), .o_data_route(o_data_route),
      .o_lowpass_amp_en(o_lowpass_amp_en), .o_slicer_en(o_slicer_en), .o_pa_mode(o_pa_mode),
      .o_tx_mod_en(o_tx_mod_en), .o_osc_en(o_osc_en), .o_synth_en(o_synth_en),
      .o_demod_en(o_demod_en), .o_freq_word(o_freq_word), .o_fsk_dev(o_fsk_dev),
      .o_pump_factor(o_pump_factor), .o_loop_div_sel(o_loop_div_sel),
      .o_mod_kind(o_mod_kind), .o_slicer_learn(o_slicer_learn));
   // second device faces the hand-driven link, for malformed frames
   tscb_device i_tscb_device_far (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk2),
      .o_lna_mode(far_lna), .o_mixer_en(), .o_if_amp_en(), .o_limiter_en(), .o_rssi_en(),
      .o_data_route(), .o_lowpass_amp_en(), .o_slicer_en(), .o_pa_mode(far_pa),
      .o_tx_mod_en(), .o_osc_en(), .o_synth_en(), .o_demod_en(), .o_freq_word(),
      .o_fsk_dev(far_dev), .o_pump_factor(), .o_loop_div_sel(), .o_mod_kind(),
      .o_slicer_learn());
   tscb_link_properties #(.HALF_CYC(4)) i_tscb_link_properties (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .serial_clk(lk.serial_clk), .serial_data(lk.serial_data),
      .strobe(lk.strobe));

   // 200 MHz system clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // watchdog, runs are a few thousand cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the read strobe
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // one word through the host, then the model follows the address
   task automatic send(input logic [2:0] a, input logic [20:0] body);
      logic [31:0] st;
      logic [23:0] w;
      int n;
      w = {a, body};
      bus_wr(`TSCB_REG_WORD, {8'h00, w});
      bus_rd(`TSCB_REG_STATUS, st);
      chk("busy", 48'h1, {47'h0, st[0]});
      // a second word while busy must be dropped, the first stays readable
      bus_wr(`TSCB_REG_WORD, 32'h00812345);
      bus_rd(`TSCB_REG_WORD, st);
      chk("word", {24'h0, w}, {16'h0, st});
      n = 0;
      while (o_busy !== 1'b0 && n < 400) begin
         @(posedge i_clk);
         n++;
      end
      chk("sent", 48'h1, {47'h0, n < 400});
      repeat (8) @(posedge i_clk);
      if (a == `TSCB_ADDR_FREQ0) freq[0] = w[21:0];
      if (a == `TSCB_ADDR_FREQ1) freq[1] = w[21:0];
      if (a == `TSCB_ADDR_MODE0) {dev, bank[0]} = w[20:0];
      if (a == `TSCB_ADDR_MODE1) {ext, bank[1]} = {w[20:15], w[12:0]};
   endtask

   task automatic ctrl(input logic m, input logic s);
      bus_wr(`TSCB_REG_CTRL, {30'h0, s, m});
      mode = m;
      stby = s;
      repeat (8) @(posedge i_clk);
   endtask

   // expected outputs of the active bank, all off in standby
   task automatic check_all();
      logic [12:0] b;
      logic [14:0] e;
      b = bank[mode];
      e = {b[1:0], b[2], b[3], b[4], b[5], b[6], b[7], b[8], b[10:9], |b[10:9], b[11],
         b[12], b[4] & b[7] & ~b[6]};
      if (!stby) e = 15'h0000;
      chk("bank", {33'h0, e}, {33'h0, obs});
      chk("misc", {12'h0, freq[mode], dev, ext}, {12'h0, o_freq_word, o_fsk_dev,
         o_pump_factor, o_loop_div_sel, o_mod_kind, o_slicer_learn});
   endtask

   // hand-made frame of n bits msb first, link clock 160 ns, idle low
   task automatic raw_send(input logic [25:0] bits, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         // next bit goes out as the clock falls, 32 cycles a bit
         lk2.serial_data <= bits[k];
         repeat (16) @(posedge i_clk);
         lk2.serial_clk <= 1'b1;
         repeat (16) @(posedge i_clk);
         lk2.serial_clk <= 1'b0;
      end
      lk2.serial_data <= 1'b0;
      repeat (16) @(posedge i_clk);
      lk2.strobe <= 1'b1;
      repeat (16) @(posedge i_clk);
      lk2.strobe <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask

   task automatic t_reset();
      logic [31:0] d;
      check_all();
      bus_rd(4'hc, d);
      chk("unmapped", 48'h0, {16'h0, d});
      $display("end of reset test");
   endtask

   // load while in standby, then wake
   task automatic t_preload();
      send(3'h3, {8'h5a, 13'h0891});
      check_all();
      ctrl(1'b0, 1'b1);
      check_all();
      $display("end of preload test");
   endtask

   // amplifier codes 01 to 11, every power amp code, demodulator on and off
   task automatic t_fields();
      logic [12:0] pats [4];
      pats = '{13'h0891, 13'h12d6, 13'h053b, 13'h1fff};
      for (int i = 0; i < 4; i++) begin
         send(3'h3, {4'ha, i[3:0], pats[i]});
         check_all();
      end
      $display("end of field test");
   endtask

   // both banks loaded, the mode pin swaps them without reloading
   task automatic t_modes();
      send(3'h0, 21'h0a5c3d);
      send(3'h1, 21'h15a3c2);
      send(3'h2, {6'h2d, 2'h0, 13'h12d6});
      check_all();
      ctrl(1'b1, 1'b1);
      check_all();
      ctrl(1'b0, 1'b1);
      check_all();
      $display("end of mode test");
   endtask

   // unused addresses load nothing, standby gates the banks
   task automatic t_ignored();
      send(3'h4, 21'h1fffff);
      send(3'h5, 21'h1fffff);
      send(3'h6, 21'h1fffff);
      check_all();
      ctrl(1'b1, 1'b0);
      check_all();
      $display("end of ignored address test");
   endtask

   // over-long frame keeps the last 24 bits; the test address loads nothing
   task automatic t_far();
      raw_send({2'b11, 3'h3, 8'ha5, 13'h0601}, 26);
      chk("far", 48'ha5d, {36'h0, far_dev, far_pa, far_lna});
      raw_send({2'b00, 3'h7, 8'h3c, 13'h0000}, 24);
      chk("far", 48'ha5d, {36'h0, far_dev, far_pa, far_lna});
      $display("end of far link test");
   endtask

   initial begin
      i_rst_n = 1'b0;
      {i_addr, i_wdata, i_wr, i_rd} = '0;
      {lk2.serial_clk, lk2.serial_data, lk2.strobe, lk2.mode_select} = 4'h0;
      lk2.standby_pin = 1'b1;
      bank = '{13'h0, 13'h0};
      freq = '{22'h0, 22'h0};
      {dev, ext, mode, stby} = '0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_preload();
      t_fields();
      t_modes();
      t_ignored();
      t_far();
      test_done();
   end
endmodule

`default_nettype wire
